/* include/tsr_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the
//          temperature sensor register block.
// Assumes: Included by bare name; definitions only.
// Notes:   Selector codes are the three low pointer bits.
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register selector codes
// ----------------------------------------------------------------------------
`define TSR_SEL_TEMP 3'h0
`define TSR_SEL_CONFIG 3'h1
`define TSR_SEL_HYST 3'h2
`define TSR_SEL_OVER 3'h3
`define TSR_SEL_ONESHOT 3'h4
`define TSR_ONESHOT_PTR 8'h04

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define TSR_PTR_RESET 8'h00
`define TSR_CFG_RESET 8'h00
`define TSR_TEMP_RESET 16'h0000
`define TSR_HYST_RESET 16'h4B00
`define TSR_OVER_RESET 16'h5000
`define TSR_DATA_MASK 16'hFFF0
`define TSR_CFG_WR_MASK 8'hBF

// ----------------------------------------------------------------------------
// Configuration bit positions
// ----------------------------------------------------------------------------
`define TSR_CFG_SHUTDOWN 0
`define TSR_CFG_CMP_INT 1
`define TSR_CFG_POLARITY 2
`define TSR_CFG_FQ_LO 3
`define TSR_CFG_FQ_HI 4
`define TSR_CFG_ONESHOT 5
`define TSR_CFG_ALERT_FN 7

// ----------------------------------------------------------------------------
// Fault queue depths
// ----------------------------------------------------------------------------
`define TSR_FQ_ONE 3'h1
`define TSR_FQ_TWO 3'h2
`define TSR_FQ_FOUR 3'h4
`define TSR_FQ_SIX 3'h6

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TSR_CLK_MHZ 100
`define TSR_CONV_PERIOD_MS 100
`define TSR_CONV_PERIOD_CYC (`TSR_CONV_PERIOD_MS * 1000 * `TSR_CLK_MHZ)

`endif

/* include/tsr_pkg.sv */
// Purpose: Types shared by the temperature sensor register block.
// Assumes: Nothing imported; users write tsr_pkg::name.
// Notes:   State encodings left to the tools.
package tsr_pkg;

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_PTR,
    LINK_HI,
    LINK_LO,
    LINK_READ
  } tsr_link_type;

  typedef enum logic [0:0] {
    CONV_IDLE,
    CONV_BUSY
  } tsr_conv_type;

endpackage

/* rtl/tsr_sensor_regs.sv */
// Purpose: Pointer-addressed register file, conversion sequencing, fault
//          queue and alert pin of a digital temperature sensor.
// Assumes: Byte-level bus framing done outside; converter outside on clk.
// Notes:   Bus pins are sampled through two flops; bus_clk edges found on clk.
`include "tsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tsr_sensor_regs #(
  parameter int CONV_PERIOD_CYC = `TSR_CONV_PERIOD_CYC
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic bus_clk, // Serial byte clock from the bus
  input wire logic bus_frame, // High for a whole transaction
  input wire logic bus_rnw, // Transaction direction, 1 read
  input wire logic [7:0] bus_wdata, // Written byte, stable at bus_clk rise
  output logic [7:0] rd_byte, // Byte presented to the bus
  input wire logic [15:0] conv_data, // Converter result
  input wire logic conv_ready, // Converter result valid pulse
  output logic conv_start, // Start one conversion, pulse
  output logic conv_power, // Converter powered
  output logic alert_function_select, // Alert-function select bit
  output logic overtemp_alert_pin // Over-temperature alert pin
);

  localparam int TW = $clog2(CONV_PERIOD_CYC) + 1;

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] sel_word(input logic [2:0] sel,
                                           input logic [15:0] temp,
                                           input logic [7:0] cfg,
                                           input logic [15:0] hyst,
                                           input logic [15:0] over);
    logic [15:0] w;
    w = temp;
    case (sel)
      `TSR_SEL_CONFIG: w = {cfg, cfg};
      `TSR_SEL_HYST: w = hyst;
      `TSR_SEL_OVER: w = over;
      default: w = temp;
    endcase
    return w;
  endfunction

  function automatic logic [2:0] fault_need(input logic [1:0] fq);
    logic [2:0] n;
    case (fq)
      2'h1: n = `TSR_FQ_TWO;
      2'h2: n = `TSR_FQ_FOUR;
      2'h3: n = `TSR_FQ_SIX;
      default: n = `TSR_FQ_ONE;
    endcase
    return n;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic s_clk_d;
  logic s_frame_d;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 11'h000;
      sync2 <= 11'h000;
      s_clk_d <= 1'b0;
      s_frame_d <= 1'b0;
    end else begin
      sync1 <= {bus_clk, bus_frame, bus_rnw, bus_wdata};
      sync2 <= sync1;
      s_clk_d <= sync2[10];
      s_frame_d <= sync2[9];
    end
  end

  wire s_frame = sync2[9];
  wire s_rnw = sync2[8];
  wire [7:0] s_wdata = sync2[7:0];
  wire clk_rise = sync2[10] & ~s_clk_d;
  wire frame_start = s_frame & ~s_frame_d;

  // --------------------------------------------------------------------------
  // Register file and link sequencing
  // --------------------------------------------------------------------------
  tsr_pkg::tsr_link_type link_st;
  logic [7:0] pointer;
  logic [7:0] cfg;
  logic [15:0] hyst_limit;
  logic [15:0] over_limit;
  logic [15:0] temp_value;
  logic [7:0] hi_hold;
  logic rd_low_next;
  logic trig_pulse;
  logic read_evt;

  wire [2:0] sel = pointer[2:0];
  wire [15:0] sel_data = sel_word(sel, temp_value, cfg, hyst_limit, over_limit);
  wire [15:0] wr_word = {hi_hold, s_wdata} & `TSR_DATA_MASK;
  wire sel_limit = (sel == `TSR_SEL_HYST) || (sel == `TSR_SEL_OVER);
  wire cfg_shutdown = cfg[`TSR_CFG_SHUTDOWN];
  wire cfg_int_mode = cfg[`TSR_CFG_CMP_INT];
  wire cfg_polarity = cfg[`TSR_CFG_POLARITY];
  wire cfg_oneshot = cfg[`TSR_CFG_ONESHOT];
  wire [1:0] cfg_fq = cfg[`TSR_CFG_FQ_HI:`TSR_CFG_FQ_LO];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_st <= tsr_pkg::LINK_IDLE;
      pointer <= `TSR_PTR_RESET;
      cfg <= `TSR_CFG_RESET;
      hyst_limit <= `TSR_HYST_RESET;
      over_limit <= `TSR_OVER_RESET;
      hi_hold <= 8'h00;
      rd_byte <= 8'h00;
      rd_low_next <= 1'b0;
      trig_pulse <= 1'b0;
      read_evt <= 1'b0;
    end else begin
      trig_pulse <= 1'b0;
      read_evt <= 1'b0;
      if (!s_frame) begin
        link_st <= tsr_pkg::LINK_IDLE;
      end else if (frame_start) begin
        read_evt <= s_rnw;
        rd_byte <= sel_data[15:8];
        rd_low_next <= 1'b1;
        link_st <= s_rnw ? tsr_pkg::LINK_READ : tsr_pkg::LINK_PTR;
      end else if (clk_rise) begin
        case (link_st)
          tsr_pkg::LINK_PTR: begin
            pointer <= s_wdata;
            trig_pulse <= (s_wdata == `TSR_ONESHOT_PTR);
            link_st <= tsr_pkg::LINK_HI;
          end
          tsr_pkg::LINK_HI: begin
            if (sel == `TSR_SEL_CONFIG) begin
              cfg <= s_wdata & `TSR_CFG_WR_MASK;
            end else begin
              hi_hold <= s_wdata;
              link_st <= tsr_pkg::LINK_LO;
            end
          end
          tsr_pkg::LINK_LO: begin
            // Temperature and one-shot data bytes are dropped here
            if (sel == `TSR_SEL_HYST) begin
              hyst_limit <= wr_word;
            end
            if (sel == `TSR_SEL_OVER) begin
              over_limit <= wr_word;
            end
            link_st <= tsr_pkg::LINK_HI;
          end
          tsr_pkg::LINK_READ: begin
            rd_byte <= rd_low_next ? sel_data[7:0] : sel_data[15:8];
            rd_low_next <= ~rd_low_next;
          end
          default: link_st <= tsr_pkg::LINK_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Conversion sequencing
  // --------------------------------------------------------------------------
  tsr_pkg::tsr_conv_type conv_st;
  logic [TW-1:0] timer;

  wire run_normal = ~cfg_shutdown & ~cfg_oneshot;
  wire periodic_due = run_normal && (timer == TW'(CONV_PERIOD_CYC - 1));
  wire oneshot_go = trig_pulse & cfg_oneshot & ~cfg_shutdown;
  wire conv_idle = (conv_st == tsr_pkg::CONV_IDLE);
  wire start_req = (periodic_due | oneshot_go) & conv_idle;
  wire result_evt = conv_ready & ~conv_idle & ~cfg_shutdown;
  wire [15:0] new_temp = conv_data & `TSR_DATA_MASK;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_st <= tsr_pkg::CONV_IDLE;
      timer <= '0;
      conv_start <= 1'b0;
      conv_power <= 1'b0;
      temp_value <= `TSR_TEMP_RESET;
    end else begin
      conv_start <= start_req;
      timer <= (run_normal && !periodic_due) ? timer + TW'(1) : '0;
      // Outside shutdown, converter stays up in normal mode, and in one-shot mode only while a conversion runs
      conv_power <= ~cfg_shutdown & (~cfg_oneshot | start_req
                    | (~conv_idle & ~conv_ready));
      if (result_evt) begin
        temp_value <= new_temp;
      end
      case (conv_st)
        tsr_pkg::CONV_IDLE: begin
          if (start_req) begin
            conv_st <= tsr_pkg::CONV_BUSY;
          end
        end
        tsr_pkg::CONV_BUSY: begin
          // Shutdown abandons a conversion in flight
          if (conv_ready || cfg_shutdown) begin
            conv_st <= tsr_pkg::CONV_IDLE;
          end
        end
        default: conv_st <= tsr_pkg::CONV_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Fault queue and alert
  // --------------------------------------------------------------------------
  logic [2:0] fault_cnt;
  logic alert_active;
  logic int_armed;

  wire is_fault = $signed(new_temp[15:4]) > $signed(over_limit[15:4]);
  wire below_hyst = $signed(new_temp[15:4]) < $signed(hyst_limit[15:4]);
  wire [2:0] cnt_inc = (fault_cnt == `TSR_FQ_SIX) ? fault_cnt : fault_cnt + 3'h1;
  wire [2:0] next_cnt = is_fault ? cnt_inc : 3'h0;
  wire reached = is_fault && (cnt_inc >= fault_need(cfg_fq));
  wire int_set = result_evt & reached & int_armed;
  wire cmp_alert = reached ? 1'b1 : (below_hyst ? 1'b0 : alert_active);
  wire int_alert = int_set | (alert_active & ~read_evt);
  wire next_alert = cfg_int_mode ? int_alert
                    : (result_evt ? cmp_alert : alert_active);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_cnt <= 3'h0;
      alert_active <= 1'b0;
      int_armed <= 1'b1;
      overtemp_alert_pin <= 1'b1;
      alert_function_select <= 1'b0;
    end else begin
      if (result_evt) begin
        fault_cnt <= next_cnt;
      end
      // Interrupt re-arms only after a drop below hysteresis
      if (int_set) begin
        int_armed <= 1'b0;
      end else if (result_evt && below_hyst) begin
        int_armed <= 1'b1;
      end
      alert_active <= next_alert;
      overtemp_alert_pin <= cfg_polarity ? next_alert : ~next_alert;
      alert_function_select <= cfg[`TSR_CFG_ALERT_FN];
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_oneshot_down;
    @(posedge clk) disable iff (sys_rst)
      (cfg_oneshot && conv_idle && !oneshot_go) |=> !conv_power;
  endproperty
  a_oneshot_down: assert property (p_oneshot_down) else $error("converter up in one-shot");

  property p_oneshot_start;
    @(posedge clk) disable iff (sys_rst)
      (oneshot_go && conv_idle) |=> conv_start ##1 (!conv_start && !conv_idle);
  endproperty
  a_oneshot_start: assert property (p_oneshot_start) else $error("one-shot not started");

  property p_trig_ignored;
    @(posedge clk) disable iff (sys_rst)
      (trig_pulse && !cfg_oneshot && !periodic_due) |=> !conv_start;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger outside one-shot");

  property p_ptr_load;
    @(posedge clk) disable iff (sys_rst)
      (s_frame && !frame_start && clk_rise && link_st == tsr_pkg::LINK_PTR)
        |=> (pointer == $past(s_wdata));
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_low_zero;
    @(posedge clk) disable iff (sys_rst)
      (temp_value[3:0] == 4'h0) && (hyst_limit[3:0] == 4'h0) && (over_limit[3:0] == 4'h0);
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low nibble not zero");

  property p_fault_clear;
    @(posedge clk) disable iff (sys_rst)
      (result_evt && !is_fault) |=> (fault_cnt == 3'h0);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault count kept");

  property p_queue_gate;
    @(posedge clk) disable iff (sys_rst)
      (result_evt && !cfg_int_mode && !alert_active && !below_hyst
        && (cnt_inc < fault_need(cfg_fq))) |=> !alert_active;
  endproperty
  a_queue_gate: assert property (p_queue_gate) else $error("alert before queue full");

  property p_int_read_clear;
    @(posedge clk) disable iff (sys_rst)
      (cfg_int_mode && alert_active && read_evt && !int_set) |=> !alert_active;
  endproperty
  a_int_read_clear: assert property (p_int_read_clear) else $error("read kept alert");

  property p_cmp_release;
    @(posedge clk) disable iff (sys_rst)
      (result_evt && !cfg_int_mode && below_hyst && !reached) |=> !alert_active;
  endproperty
  a_cmp_release: assert property (p_cmp_release) else $error("alert not released");

  property p_polarity;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> (overtemp_alert_pin == ($past(cfg_polarity) ? alert_active : !alert_active));
  endproperty
  a_polarity: assert property (p_polarity) else $error("alert pin polarity wrong");

  c_oneshot: cover property (@(posedge clk) disable iff (sys_rst) oneshot_go && conv_idle);
  c_alert: cover property (@(posedge clk) disable iff (sys_rst) !alert_active ##1 alert_active);
  c_read: cover property (@(posedge clk) disable iff (sys_rst) read_evt ##[1:40] clk_rise);

endmodule

`default_nettype wire

/* sim/temp_sensor_regs_oneshot_alert_tb.sv */
// Purpose: Self-checking bench for the sensor register block.
// Assumes: Converter answered by the bench three cycles after each start.
// Notes:   Conversion period shortened to 200 cycles.
`include "tsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_regs_oneshot_alert_tb;
  localparam int CONV_CYC = 200;
  localparam logic [2:0] DEPTH [4] = '{`TSR_FQ_ONE, `TSR_FQ_TWO, `TSR_FQ_FOUR, `TSR_FQ_SIX};
  logic clk;
  logic sys_rst;
  wire logic bus_clk;
  wire logic bus_frame;
  wire logic bus_rnw;
  wire logic [7:0] bus_wdata;
  wire logic [7:0] rd_byte;
  logic [15:0] conv_data;
  logic conv_ready;
  wire logic conv_start;
  wire logic conv_power;
  wire logic alert_function_select;
  wire logic overtemp_alert_pin;
  logic [15:0] cur_temp;
  logic [15:0] rd_val;
  int conv_count;
  int n;
  int err_count;
  int comparisons;

  tsr_sensor_regs #(.CONV_PERIOD_CYC(CONV_CYC)) dut (
    .clk(clk), .sys_rst(sys_rst), .bus_clk(bus_clk), .bus_frame(bus_frame),
    .bus_rnw(bus_rnw), .bus_wdata(bus_wdata), .rd_byte(rd_byte), .conv_data(conv_data),
    .conv_ready(conv_ready), .conv_start(conv_start), .conv_power(conv_power),
    .alert_function_select(alert_function_select), .overtemp_alert_pin(overtemp_alert_pin)
  );

  tsr_host_model host (
    .clk(clk), .bus_clk(bus_clk), .bus_frame(bus_frame), .bus_rnw(bus_rnw),
    .bus_wdata(bus_wdata), .rd_byte(rd_byte)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Converter stand-in
  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      repeat (3) @(posedge clk);
      #1 conv_data = cur_temp;
      conv_ready = 1'b1;
      @(posedge clk);
      #1 conv_ready = 1'b0;
      conv_data = ~conv_data;
      conv_count++;
    end
  end

  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [2:0] sel, input int nb, input logic [15:0] exp);
    logic [15:0] v;
    host.write_bytes(sel, 16'h0000, 0);
    host.read_bytes(nb, v);
    check_reg(v, exp);
  endtask

  task automatic set_cfg(input logic [7:0] c);
    host.write_bytes(`TSR_SEL_CONFIG, {8'h00, c}, 1);
  endtask

  // Waits for the next result; trig issues a one-shot trigger first
  task automatic convert(input logic [15:0] t, input logic trig);
    int start;
    cur_temp = t;
    start = conv_count;
    if (trig)
      host.write_bytes(`TSR_SEL_ONESHOT, 16'h0000, 0);
    for (int i = 0; i < 2 * CONV_CYC && conv_count == start; i++) @(posedge clk);
    check_pin(conv_count != start, 1'b1);
    repeat (2) @(posedge clk);
  endtask

  task automatic results();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #500000;
    err_count++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    conv_data = 16'h0000;
    conv_ready = 1'b0;
    cur_temp = 16'h0000;
    conv_count = 0;
    err_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    // Reset state and access kinds
    check_pin(overtemp_alert_pin, 1'b1);
    host.read_bytes(2, rd_val);
    check_reg(rd_val, `TSR_TEMP_RESET);
    rd(`TSR_SEL_CONFIG, 1, {8'h00, `TSR_CFG_RESET});
    rd(`TSR_SEL_HYST, 2, `TSR_HYST_RESET);
    rd(`TSR_SEL_OVER, 2, `TSR_OVER_RESET);
    host.write_bytes(`TSR_SEL_HYST, 16'h1234, 2);
    rd(`TSR_SEL_HYST, 2, 16'h1230);
    host.write_bytes(`TSR_SEL_HYST, `TSR_HYST_RESET, 2);
    host.write_bytes(`TSR_SEL_TEMP, 16'h7FFF, 2);
    rd(`TSR_SEL_TEMP, 2, 16'h0000);
    set_cfg(8'hFF);
    rd(`TSR_SEL_CONFIG, 1, 16'h00BF);
    check_pin(alert_function_select, 1'b1);
    check_pin(overtemp_alert_pin, 1'b0);
    set_cfg(8'h00);
    // Periodic result, sign and byte order
    convert(16'hE705, 1'b0);
    rd(`TSR_SEL_TEMP, 2, 16'hE700);
    rd(`TSR_SEL_ONESHOT, 2, 16'hE700);
    // Shutdown stops conversions until cleared
    set_cfg(8'h01);
    check_pin(conv_power, 1'b0);
    n = conv_count;
    repeat (3 * CONV_CYC) @(posedge clk);
    check_reg(16'(conv_count), 16'(n));
    set_cfg(8'h00);
    convert(16'h0190, 1'b0);
    check_pin(conv_power, 1'b1);
    // Trigger location is inert in normal mode
    n = conv_count;
    host.write_bytes(`TSR_SEL_ONESHOT, 16'h0000, 0);
    check_reg(16'(conv_count), 16'(n));
    // One-shot entry powers down at once
    set_cfg(8'h20);
    check_pin(conv_power, 1'b0);
    n = conv_count;
    repeat (3 * CONV_CYC) @(posedge clk);
    check_reg(16'(conv_count), 16'(n));
    // Every fault-queue depth, comparator mode, active low
    for (int q = 0; q < 4; q++) begin
      set_cfg(8'h20 | 8'(q << 3));
      repeat (int'(DEPTH[q]) - 1) convert(16'h6400, 1'b1);
      check_pin(overtemp_alert_pin, 1'b1);
      convert(16'h6400, 1'b1);
      check_pin(overtemp_alert_pin, 1'b0);
      check_pin(conv_power, 1'b0);
      rd(`TSR_SEL_ONESHOT, 2, 16'h6400);
      check_pin(overtemp_alert_pin, 1'b0);
      convert(16'h1000, 1'b1);
      check_pin(overtemp_alert_pin, 1'b1);
    end
    // Broken runs of faults, negative value must not count
    set_cfg(8'h28);
    convert(16'h6400, 1'b1);
    convert(16'hE700, 1'b1);
    convert(16'h6400, 1'b1);
    check_pin(overtemp_alert_pin, 1'b1);
    convert(16'h6400, 1'b1);
    check_pin(overtemp_alert_pin, 1'b0);
    convert(16'h1000, 1'b1);
    // Interrupt mode, active high, cleared by a read
    set_cfg(8'h26);
    check_pin(overtemp_alert_pin, 1'b0);
    convert(16'h6400, 1'b1);
    check_pin(overtemp_alert_pin, 1'b1);
    rd(`TSR_SEL_CONFIG, 1, 16'h0026);
    check_pin(overtemp_alert_pin, 1'b0);
    // Re-armed by a cool result, then a temperature read clears it too
    convert(16'h1000, 1'b1);
    convert(16'h6400, 1'b1);
    check_pin(overtemp_alert_pin, 1'b1);
    rd(`TSR_SEL_TEMP, 2, 16'h6400);
    check_pin(overtemp_alert_pin, 1'b0);
    results();
  end
endmodule

`default_nettype wire

/* sim/tsr_host_model.sv */
// Purpose: Bus master model that frames bytes towards the sensor registers.
// Assumes: Byte-level framing only; no addressing or acknowledge.
// Notes:   Byte clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module tsr_host_model (
  input wire logic clk, // System clock, used only to place frame starts
  output logic bus_clk, // Byte clock, still outside frames
  output logic bus_frame, // Transaction window
  output logic bus_rnw, // Direction, 1 read
  output logic [7:0] bus_wdata, // Written byte
  input wire logic [7:0] rd_byte // Byte offered by the device
);
  initial begin
    bus_clk = 1'b0;
    bus_frame = 1'b0;
    bus_rnw = 1'b0;
    bus_wdata = 8'hA5;
  end

  // Frames open one step after a clock edge so no pin moves on a sampling edge
  task automatic frame_open();
    @(posedge clk);
    #1;
  endtask

  // One byte slot; data was set up a half period before the rise
  task automatic slot(output logic [7:0] got);
    #62.5 bus_clk = 1'b1;
    got = rd_byte;
    #62.5 bus_clk = 1'b0;
  endtask

  task automatic frame_close();
    #40 bus_frame = 1'b0;
    // Released data lines must not keep the last byte
    bus_wdata = ~bus_wdata;
    #100;
  endtask

  task automatic write_bytes(input logic [2:0] sel, input logic [15:0] data, input int n);
    logic [7:0] got;
    frame_open();
    bus_rnw = 1'b0;
    bus_frame = 1'b1;
    bus_wdata = {5'h00, sel};
    slot(got);
    if (n == 2) begin
      bus_wdata = data[15:8];
      slot(got);
    end
    if (n > 0) begin
      bus_wdata = data[7:0];
      slot(got);
    end
    frame_close();
  endtask

  task automatic read_bytes(input int n, output logic [15:0] val);
    logic [7:0] got;
    frame_open();
    bus_rnw = 1'b1;
    bus_frame = 1'b1;
    val = 16'h0000;
    for (int i = 0; i < n; i++) begin
      slot(got);
      val = {val[7:0], got};
    end
    frame_close();
  endtask
endmodule

`default_nettype wire
